// ### hdl/wdrt_watchdog.sv
// watchdog reset timer: 16-bit counter, two-step clear, internal reset
`timescale 1ns/1ns
// Overview of operation
// - sixteen-bit counter, one step per tick
// - external reset stops and zeroes counter
// - start bit write starts the counter
// - software cannot stop a running watchdog
// - clear needs arm then start next instruction
// - arm bit self-clears third tick after set
// - count FFFC gives four-tick internal reset
// - watchdog reset keeps running, sets source flag
module wdrt_watchdog
    import wdrt_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // machine-cycle tick
    input  wire logic        tick,
    // software register writes
    input  wire wdrt_sw_t    sw,
    // instruction boundary strobe
    input  wire logic        instr_done,
    // source flag clear by software
    input  wire logic        src_flag_clr,
    // outputs
    output wdrt_stat_t       stat,
    output logic             wd_reset
);

    wdrt_state_t state;
    wdrt_state_t next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [2:0]  rst_cnt;
    logic [2:0]  next_rst_cnt;
    logic        src_flag;
    logic        next_src_flag;
    logic        arm;
    logic        pending;
    logic        next_pending;

    // decode of the two software writes
    wire set_start = sw.wr_ien_b && sw.wdata[WDRT_START_BIT];
    wire set_arm   = sw.wr_ien_a && sw.wdata[WDRT_ARM_BIT];
    // arm must be followed by start in the very next instruction
    wire clear_req = set_start && arm && pending;
    wire running   = (state != WDRT_IDLE);
    wire timeout   = (state == WDRT_RUN) && tick && (count == WDRT_CNT_TIMEOUT - 16'h0001);
    wire rst_done  = (state == WDRT_RESET) && tick && (rst_cnt == WDRT_RST_CYCLES - 3'h1);

    wdrt_arm_timer u_arm (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (tick),
        .set_arm (set_arm),
        .consume (clear_req),
        .arm     (arm)
    );

    // pending marks the instruction right after arming
    assign next_pending = set_arm ? 1'b1 : ((instr_done || clear_req) ? 1'b0 : pending);

    always_comb begin
        next_state = state;
        case (state)
            WDRT_IDLE:  if (set_start) next_state = WDRT_RUN;
            WDRT_RUN:   if (timeout) next_state = WDRT_RESET;
            // no software path back to idle
            WDRT_RESET: if (rst_done) next_state = WDRT_RUN;
            default:    next_state = WDRT_IDLE;
        endcase
    end

    // lone start writes do not touch the count
    assign next_count = clear_req ? WDRT_CNT_RESET :
                        (running && tick) ? count + 16'h0001 : count;
    assign next_rst_cnt = (state != WDRT_RESET) ? 3'h0 : (tick ? rst_cnt + 3'h1 : rst_cnt);
    // set wins over software clear
    assign next_src_flag = timeout ? 1'b1 : (src_flag_clr ? 1'b0 : src_flag);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= WDRT_IDLE;
            count    <= WDRT_CNT_RESET;
            rst_cnt  <= 3'h0;
            src_flag <= 1'b0;
            pending  <= 1'b0;
        end else begin
            state    <= next_state;
            count    <= next_count;
            rst_cnt  <= next_rst_cnt;
            src_flag <= next_src_flag;
            pending  <= next_pending;
        end
    end

    assign wd_reset       = (state == WDRT_RESET);
    assign stat.running   = running;
    assign stat.arm       = arm;
    assign stat.src_flag  = src_flag;
    assign stat.count     = count;

    // observer for the internal reset length: ticks seen while it stands
    logic [2:0] rst_ticks;
    logic [2:0] next_rst_ticks;

    assign next_rst_ticks = !wd_reset ? 3'h0 : (tick ? rst_ticks + 3'h1 : rst_ticks);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_ticks <= 3'h0;
        end else begin
            rst_ticks <= next_rst_ticks;
        end
    end

    // counting, starting and stopping
    a_reset_stopped: assert property (@(posedge sys_clk)
        $rose(rst_b) |-> (count == 16'h0000 && !running))
        else $error("watchdog not stopped and zero after reset");
    a_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !running |-> count == WDRT_CNT_RESET)
        else $error("stopped watchdog holds a nonzero count");
    a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (running && tick && !clear_req) |=> count == $past(count) + 16'h0001)
        else $error("count did not advance on tick");
    a_hold_no_tick: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (running && !tick && !clear_req) |=> count == $past(count))
        else $error("count moved without a tick");
    a_wrap_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (running && tick && !clear_req && count == 16'hffff) |=> count == WDRT_CNT_RESET)
        else $error("count did not wrap to zero");
    a_start_runs: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!running && set_start) |=> running)
        else $error("start bit did not start watchdog");
    a_start_from_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!running && set_start) |=> count == WDRT_CNT_RESET)
        else $error("watchdog did not start from zero");
    a_never_stops: assert property (@(posedge sys_clk) disable iff (!rst_b)
        running |=> running)
        else $error("running watchdog stopped");

    // clear sequence and arm window
    a_clear_seq: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clear_req |=> count == 16'h0000)
        else $error("clear sequence did not zero count");
    a_arm_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        set_arm |=> arm)
        else $error("arm write did not set the clear-arm bit");
    a_arm_only_sw: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!arm && !set_arm) |=> !arm)
        else $error("clear-arm bit set without a write");
    a_pending_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        set_arm |=> pending)
        else $error("arm write did not open the next-instruction window");
    a_window_closed: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_done && !set_arm) |=> !pending)
        else $error("window still open after another instruction");
    a_clear_used: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clear_req && !set_arm) |=> !arm)
        else $error("clear-arm bit survived a completed clear");
    a_arm_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (arm && !tick && !clear_req) |=> arm)
        else $error("clear-arm bit dropped between ticks");
    a_arm_expiry: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($fell(arm) && $past(rst_b) && !$past(clear_req)) |-> $past(tick))
        else $error("clear-arm bit expired off a tick");
    a_lone_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (running && set_start && !arm && !tick) |=> count == $past(count))
        else $error("lone start altered count");
    a_lone_start_tick: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (running && set_start && !arm && tick) |=> count == $past(count) + 16'h0001)
        else $error("lone start disturbed counting");

    // internal reset
    a_timeout_rst: assert property (@(posedge sys_clk) disable iff (!rst_b)
        timeout |=> wd_reset && src_flag)
        else $error("timeout gave no reset or flag");
    a_rst_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(wd_reset) |-> count == WDRT_CNT_TIMEOUT)
        else $error("internal reset entered off the timeout state");
    a_rst_from_tick: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(wd_reset) |-> $past(tick))
        else $error("internal reset entered without a tick");
    a_rst_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wd_reset && !tick) |=> wd_reset)
        else $error("internal reset dropped between ticks");
    a_rst_no_overrun: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wd_reset |-> rst_ticks < WDRT_RST_CYCLES)
        else $error("internal reset longer than four ticks");
    a_rst_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($fell(wd_reset) && running) |-> rst_ticks == WDRT_RST_CYCLES)
        else $error("internal reset shorter than four ticks");
    a_rst_bounded: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (rst_done) |=> !wd_reset && running)
        else $error("watchdog reset did not end running");

    // reset-source flag
    a_src_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(src_flag) |-> wd_reset)
        else $error("source flag set outside an internal reset");
    a_src_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (src_flag && !src_flag_clr) |=> src_flag)
        else $error("source flag lost without a clear");
    a_src_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (src_flag_clr && !timeout) |=> !src_flag)
        else $error("source flag not cleared by software");
    a_src_source: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!src_flag && !timeout) |=> !src_flag)
        else $error("source flag set without a timeout");
    a_src_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (timeout && src_flag_clr) |=> src_flag)
        else $error("software clear beat the timeout set");

    // main scenarios
    c_start:   cover property (@(posedge sys_clk) disable iff (!rst_b) !running && set_start);
    c_clear:   cover property (@(posedge sys_clk) disable iff (!rst_b) clear_req);
    c_timeout: cover property (@(posedge sys_clk) disable iff (!rst_b) timeout);
    c_expire:  cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(arm) && !clear_req);
    c_src_clr: cover property (@(posedge sys_clk) disable iff (!rst_b) src_flag && src_flag_clr);

endmodule

// ### shared/wdrt_pkg.sv
// package: constants and carrier types for the watchdog reset timer
package wdrt_pkg;

    localparam int          WDRT_CNT_W        = 16;
    localparam logic [15:0] WDRT_CNT_RESET    = 16'h0000;
    localparam logic [15:0] WDRT_CNT_TIMEOUT  = 16'hFFFC;
    localparam logic [2:0]  WDRT_RST_CYCLES   = 3'h4;
    localparam logic [1:0]  WDRT_ARM_CYCLES   = 2'h3;
    localparam int          WDRT_START_BIT    = 6;
    localparam int          WDRT_ARM_BIT      = 6;
    localparam int          WDRT_SRC_BIT      = 6;
    // one machine cycle per tick: oscillator / 12
    localparam int          WDRT_OSC_PER_TICK = 12;
    localparam logic [7:0]  WDRT_FLAG_RESET   = 8'h00;

    // software register write strobes, one pulse per instruction
    typedef struct packed {
        logic       wr_ien_a;
        logic       wr_ien_b;
        logic [7:0] wdata;
    } wdrt_sw_t;

    // observable watchdog state
    typedef struct packed {
        logic        running;
        logic        arm;
        logic        src_flag;
        logic [15:0] count;
    } wdrt_stat_t;

    typedef enum logic [1:0] {
        WDRT_IDLE,
        WDRT_RUN,
        WDRT_RESET
    } wdrt_state_t;

endpackage

// ### hdl/wdrt_arm_timer.sv
// clear-arm bit with hardware self-clear after the third tick
`timescale 1ns/1ns
module wdrt_arm_timer
    import wdrt_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // control
    input  wire logic tick,
    input  wire logic set_arm,
    input  wire logic consume,
    // state
    output logic      arm
);

    logic [1:0] age;
    logic [1:0] next_age;
    logic       next_arm;
    wire        expire = arm && tick && (age == WDRT_ARM_CYCLES - 2'h1);

    // a new set restarts the window; expiry closes it
    assign next_arm = set_arm ? 1'b1 : ((consume || expire) ? 1'b0 : arm);
    assign next_age = set_arm ? 2'h0 : ((arm && tick) ? age + 2'h1 : age);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            arm <= 1'b0;
            age <= 2'h0;
        end else begin
            arm <= next_arm;
            age <= next_age;
        end
    end

    a_arm_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (arm && tick && age == 2'h2 && !set_arm) |=> !arm)
        else $error("clear-arm bit not cleared on third tick");

endmodule

// ### dv/tb_top.sv
// self-checking testbench for the watchdog reset timer
`timescale 1ns/1ns
module tb_top
    import wdrt_pkg::*;
;
    logic        sys_clk;
    logic        rst_b;
    logic        tick;
    wdrt_sw_t    sw;
    logic        instr_done;
    logic        src_flag_clr;
    wdrt_stat_t  stat;
    logic        wd_reset;
    logic [19:0] exp_q[$];
    int          bad_count;
    int          checks;
    int          seed;
    int          n;

    wdrt_watchdog wdrt_watchdog_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick), .sw(sw), .instr_done(instr_done),
        .src_flag_clr(src_flag_clr), .stat(stat), .wd_reset(wd_reset)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [19:0] seen, input logic [19:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %0t state %h expected %h", $time, seen, want);
        end
    endtask

    // one instruction slot, inputs change at the falling edge
    task automatic drv(input logic t, input logic a, input logic b, input logic [7:0] d,
                       input logic done, input logic clr);
        @(negedge sys_clk);
        tick = t;
        sw = {a, b, d};
        instr_done = done;
        src_flag_clr = clr;
    endtask

    // idle slot, then note the state expected before the next rising edge
    task automatic ex(input logic [3:0] f, input logic [15:0] c);
        drv(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        exp_q.push_back({f, c});
    endtask

    always @(posedge sys_clk) begin
        if (exp_q.size() > 0) begin
            check({wd_reset, stat}, exp_q.pop_front());
        end
    end

    task automatic finish_test();
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] cnt;
        seed = 32'h514d_a3fd;
        bad_count = 0;
        checks = 0;
        rst_b = 1'b0;
        tick = 1'b0;
        sw = '0;
        instr_done = 1'b0;
        src_flag_clr = 1'b0;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b0000, 16'h0000);
        drv(1'b0, 1'b0, 1'b1, 8'h40 | 8'($random(seed)), 1'b0, 1'b0);
        ex(4'b0100, 16'h0000);
        cnt = 16'h0000;
        repeat (12) begin
            n = $random(seed);
            drv(n[0], 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
            cnt = cnt + 16'(n[0]);
        end
        ex(4'b0100, cnt);
        drv(1'b0, 1'b0, 1'b1, 8'hbf & 8'($random(seed)), 1'b0, 1'b0);
        drv(1'b0, 1'b0, 1'b1, 8'h40, 1'b0, 1'b0);
        ex(4'b0100, cnt);
        drv(1'b0, 1'b1, 1'b0, 8'h40, 1'b0, 1'b0);
        ex(4'b0110, cnt);
        drv(1'b0, 1'b0, 1'b1, 8'h40, 1'b0, 1'b0);
        ex(4'b0100, 16'h0000);
        drv(1'b0, 1'b1, 1'b0, 8'h40, 1'b0, 1'b0);
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b0110, 16'h0002);
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b0100, 16'h0003);
        drv(1'b0, 1'b0, 1'b1, 8'h40, 1'b0, 1'b0);
        ex(4'b0100, 16'h0003);
        // another instruction between arm and start closes the window
        drv(1'b0, 1'b1, 1'b0, 8'h40, 1'b0, 1'b0);
        drv(1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
        drv(1'b0, 1'b0, 1'b1, 8'h40, 1'b0, 1'b0);
        ex(4'b0110, 16'h0003);
        repeat (65528) drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b0100, 16'hfffb);
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b1101, 16'hfffc);
        // the count keeps stepping through the internal reset
        repeat (3) drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b1101, 16'hffff);
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b0101, 16'h0000);
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b0101, 16'h0001);
        drv(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
        ex(4'b0100, 16'h0001);
        // let the last note be checked before the external reset lands
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        rst_b = 1'b0;
        ex(4'b0000, 16'h0000);
        rst_b = 1'b1;
        drv(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        ex(4'b0000, 16'h0000);
        for (n = 0; n < 4 && exp_q.size() > 0; n++) @(negedge sys_clk);
        if (exp_q.size() > 0) begin
            bad_count++;
            $display("[ERR] %0t expectations left unchecked", $time);
        end
        finish_test();
    end
endmodule
